/* rtl/hxrl_map.vh */
/*
 Constants for the hex record loader: record types, field codes,
 ASCII codes and sizes. Assumes inclusion by rtl/hxrl_*.v files only.
*/
`ifndef HXRL_MAP_VH
`define HXRL_MAP_VH
`define HXRL_CH_COLON 8'h3A
`define HXRL_TYPE_DATA 8'h00
`define HXRL_TYPE_EOF 8'h01
`define HXRL_TYPE_EXT 8'h02
`define HXRL_TYPE_START 8'h03
`define HXRL_LEN_EXT 8'h02
`define HXRL_LEN_START 8'h04
`define HXRL_LEN_EOF 8'h00
`define HXRL_SEG_SHIFT 4
`define HXRL_ADDR_W 20
`define HXRL_SEG_RESET 16'h0000
`endif

/* rtl/hxrl_hex_digit.v */
/*
 ASCII to nibble decoder for the hex record loader.
 Assumes one character strobe per cycle from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module hxrl_hex_digit
(
   input wire [7:0] ascii_char,
   output reg [3:0] nibble,
   output reg is_hex
);
   // Maps 0-9, A-F and a-f; anything else flags not hex.
   always @*
   begin
      nibble = 4'h0;
      is_hex = 1'b1;
      if (ascii_char >= 8'h30 && ascii_char <= 8'h39)
         nibble = ascii_char[3:0];
      else if ((ascii_char >= 8'h41 && ascii_char <= 8'h46) ||
               (ascii_char >= 8'h61 && ascii_char <= 8'h66))
         nibble = ascii_char[3:0] + 4'h9;
      else
         is_hex = 1'b0;
   end
endmodule // hxrl_hex_digit
`default_nettype wire

/* rtl/hxrl_loader.v */
/*
 Hex record loader: parses ASCII hex records from a byte stream and writes
 data bytes to a memory write port. Assumes rx_valid/rx_char come from a
 receiver in the ref_clk domain, and the memory takes one write per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hxrl_map.vh"
module hxrl_loader
(
   input wire ref_clk,
   input wire reset_n,
   input wire rx_valid,
   input wire [7:0] rx_char,
   output reg mem_wr_q,
   output reg [19:0] mem_addr_q,
   output reg [7:0] mem_data_q,
   output reg rec_err_q,
   output reg load_done_q,
   output reg start_valid_q,
   output reg [19:0] start_addr_q
);
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_LEN = 6'h02;
   localparam [5:0] S_ADDR = 6'h04;
   localparam [5:0] S_TYPE = 6'h08;
   localparam [5:0] S_DATA = 6'h10;
   localparam [5:0] S_SUM = 6'h20;

   // Segment plus offset gives the absolute address.
   function [19:0] abs_addr;
      input [15:0] seg;
      input [15:0] off;
      begin
         abs_addr = {seg, 4'h0} + {4'h0, off};
      end
   endfunction

   wire [3:0] nib;
   wire is_hex;
   reg [5:0] state_q;
   reg hi_q;
   reg [3:0] hi_nib_q;
   reg [7:0] len_q;
   reg [7:0] cnt_q;
   reg [7:0] type_q;
   reg [7:0] sum_q;
   reg [15:0] off_q;
   reg [15:0] seg_q;
   reg [31:0] pay_q;
   reg bad_q;
   reg [19:0] buf_addr [0:255];
   reg [7:0] buf_data [0:255];
   reg [7:0] play_q;
   reg [7:0] play_n_q;
   reg play_on_q;
   wire [7:0] byte_v;
   wire byte_ok;
   wire [7:0] sum_new;

   hxrl_hex_digit u_digit
   (
      .ascii_char(rx_char),
      .nibble(nib),
      .is_hex(is_hex)
   );

   assign byte_v = {hi_nib_q, nib};
   assign byte_ok = rx_valid && is_hex && !hi_q;
   assign sum_new = sum_q + byte_v;

   // Record parser; data bytes are held until the checksum proves good.
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= S_IDLE;
         hi_q <= 1'b1;
         hi_nib_q <= 4'h0;
         len_q <= 8'h00;
         cnt_q <= 8'h00;
         type_q <= 8'h00;
         sum_q <= 8'h00;
         off_q <= 16'h0000;
         seg_q <= `HXRL_SEG_RESET;
         pay_q <= 32'h00000000;
         bad_q <= 1'b0;
         rec_err_q <= 1'b0;
         load_done_q <= 1'b0;
         start_valid_q <= 1'b0;
         start_addr_q <= 20'h00000;
         play_n_q <= 8'h00;
         play_on_q <= 1'b0;
      end
      else
      begin
         rec_err_q <= 1'b0;
         if (play_on_q && play_q == play_n_q)
            play_on_q <= 1'b0;
         if (rx_valid && rx_char == `HXRL_CH_COLON && !play_on_q)
         begin
            // A colon opens a fresh record unless a data record replay is in progress.
            state_q <= S_LEN;
            hi_q <= 1'b1;
            sum_q <= 8'h00;
            cnt_q <= 8'h00;
            bad_q <= 1'b0;
            if (load_done_q)
            begin
               load_done_q <= 1'b0;
               seg_q <= `HXRL_SEG_RESET;
               start_valid_q <= 1'b0;
            end
         end
         else if (rx_valid && state_q != S_IDLE && !is_hex)
         begin
            state_q <= S_IDLE;
            rec_err_q <= 1'b1;
         end
         else if (rx_valid && state_q != S_IDLE)
         begin
            hi_q <= ~hi_q;
            hi_nib_q <= nib;
         end
         if (byte_ok && state_q != S_IDLE && !play_on_q)
         begin
            sum_q <= sum_new;
            cnt_q <= cnt_q + 8'h01;
            case (state_q)
               S_LEN:
               begin
                  len_q <= byte_v;
                  cnt_q <= 8'h00;
                  state_q <= S_ADDR;
               end
               S_ADDR:
               begin
                  off_q <= {off_q[7:0], byte_v};
                  if (cnt_q == 8'h01)
                  begin
                     cnt_q <= 8'h00;
                     state_q <= S_TYPE;
                  end
               end
               S_TYPE:
               begin
                  type_q <= byte_v;
                  cnt_q <= 8'h00;
                  state_q <= (len_q == 8'h00) ? S_SUM : S_DATA;
                  if (byte_v > `HXRL_TYPE_START ||
                      (byte_v == `HXRL_TYPE_EXT && len_q != `HXRL_LEN_EXT) ||
                      (byte_v == `HXRL_TYPE_START &&
                       len_q != `HXRL_LEN_START) ||
                      (byte_v == `HXRL_TYPE_EOF && len_q != `HXRL_LEN_EOF) ||
                      (byte_v != `HXRL_TYPE_DATA && off_q != 16'h0000))
                     bad_q <= 1'b1;
               end
               S_DATA:
               begin
                  pay_q <= {pay_q[23:0], byte_v};
                  buf_data[cnt_q] <= byte_v;
                  buf_addr[cnt_q] <= abs_addr(seg_q, off_q + {8'h00, cnt_q});
                  if (cnt_q + 8'h01 == len_q)
                     state_q <= S_SUM;
               end
               S_SUM:
               begin
                  state_q <= S_IDLE;
                  if (sum_new != 8'h00 || bad_q)
                     rec_err_q <= 1'b1;
                  else
                     case (type_q)
                        `HXRL_TYPE_DATA:
                        begin
                           play_n_q <= len_q;
                           play_on_q <= (len_q != 8'h00);
                        end
                        `HXRL_TYPE_EXT:
                           seg_q <= pay_q[15:0];
                        `HXRL_TYPE_START:
                        begin
                           start_addr_q <= abs_addr(pay_q[31:16],
                              pay_q[15:0]);
                           start_valid_q <= 1'b1;
                        end
                        `HXRL_TYPE_EOF:
                           load_done_q <= 1'b1;
                        default:
                           rec_err_q <= 1'b1;
                     endcase
               end
               default:
                  state_q <= S_IDLE;
            endcase
         end
      end
   end

   // Replays a checked data record into memory, one byte per cycle.
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         play_q <= 8'h00;
         mem_wr_q <= 1'b0;
         mem_addr_q <= 20'h00000;
         mem_data_q <= 8'h00;
      end
      else
      begin
         mem_wr_q <= 1'b0;
         if (play_on_q && play_q != play_n_q)
         begin
            mem_wr_q <= 1'b1;
            mem_addr_q <= buf_addr[play_q];
            mem_data_q <= buf_data[play_q];
            play_q <= play_q + 8'h01;
         end
         else
            play_q <= 8'h00;
      end
   end
endmodule // hxrl_loader
`default_nettype wire

/* verif/hxrl_loader_assertions.sv */
/* Port checker for hxrl_loader.
 Assumes it is bound to every loader instance, one clock. */
`timescale 1ns/10ps
`default_nettype none
module hxrl_chk
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   input wire logic mem_wr_q,
   input wire logic [19:0] mem_addr_q,
   input wire logic [7:0] mem_data_q,
   input wire logic rec_err_q,
   input wire logic load_done_q,
   input wire logic start_valid_q,
   input wire logic [19:0] start_addr_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Write bursts, error pulses and the done level against their causes.
   sequence s_wr2; mem_wr_q ##1 mem_wr_q; endsequence
   property p_step;
      s_wr2 |-> mem_addr_q == $past(mem_addr_q) + 20'h1; endproperty
   a_step: assert property (p_step) else $error("addr step");
   property p_pulse; rec_err_q |=> !rec_err_q; endproperty
   a_pulse: assert property (p_pulse) else $error("err width");
   property p_nowr; rec_err_q |-> !mem_wr_q; endproperty
   a_nowr: assert property (p_nowr) else $error("write on error");
   property p_hold;
      load_done_q && !(rx_valid && rx_char == 8'h3A) |=> load_done_q;
   endproperty
   a_hold: assert property (p_hold) else $error("done lost");
   property p_clr;
      $fell(load_done_q) |-> $past(rx_valid) && $past(rx_char) == 8'h3A;
   endproperty
   a_clr: assert property (p_clr) else $error("done cleared");
   property p_wr;
      $rose(mem_wr_q) |-> $past(rx_valid, 2) || $past(rx_valid, 3);
   endproperty
   a_wr: assert property (p_wr) else $error("write timing");
   property p_st;
      $rose(start_valid_q) |-> $past(rx_valid) || $past(rx_valid, 2);
   endproperty
   a_st: assert property (p_st) else $error("start timing");
   property p_end; load_done_q |-> !mem_wr_q; endproperty
   a_end: assert property (p_end) else $error("write after end");
endmodule // hxrl_chk
bind hxrl_loader hxrl_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .rx_valid(rx_valid), .rx_char(rx_char), .mem_wr_q(mem_wr_q),
   .mem_addr_q(mem_addr_q), .mem_data_q(mem_data_q),
   .rec_err_q(rec_err_q), .load_done_q(load_done_q),
   .start_valid_q(start_valid_q), .start_addr_q(start_addr_q));
`default_nettype wire

/* verif/hxrl_host_model.sv */
/* Host model sending ASCII hex records.
 Assumes the bench fills dat before each send_rec call. */
`timescale 1ns/10ps
`default_nettype none
module hxrl_host
(
   input wire logic ref_clk,
   output logic rx_valid,
   output logic [7:0] rx_char
);
   logic [7:0] dat [0:15];
   logic [7:0] cs;
   logic lc;
   integer i;
   // Idle line at time zero.
   initial
   begin
      rx_valid = 1'b0;
      rx_char = 8'h00;
      lc = 1'b0;
   end
   // Digit for one nibble, upper case unless lc asks for lower case.
   function automatic [7:0] hx(input [3:0] v);
      hx = (v < 4'hA) ? 8'h30 + v : (lc ? 8'h57 : 8'h37) + v;
   endfunction
   // One character, then an idle cycle showing the inverted value.
   task put(input [7:0] c);
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_char = c;
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_char = ~c;
   endtask
   // One byte as two digits, high digit first.
   task pb(input [7:0] b);
      put(hx(b[7:4]));
      put(hx(b[3:0]));
      cs = cs + b;
   endtask
   // Separator, colon, fields; bad 1 spoils the sum, 2 sends a non-digit.
   task send_rec(input [7:0] t, input [15:0] a, input [7:0] n,
                 input [1:0] bad);
      cs = 8'h00;
      put(8'h0D);
      put(8'h3A);
      pb(n);
      pb(a[15:8]);
      pb(a[7:0]);
      pb(t);
      for (i = 0; i < n; i = i + 1) pb(dat[i]);
      if (bad == 2'h2) put(8'h47);
      else pb(8'h00 - cs + {7'h00, bad[0]});
      repeat (24) @(negedge ref_clk);
   endtask
endmodule // hxrl_host
`default_nettype wire

/* verif/hxrl_loader_tb.sv */
/* Self-checking bench for hxrl_loader.
 Assumes the host model drives every character. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
   n_mismatch = n_mismatch + 1; \
   $display("MISMATCH %0t got %0h exp %0h", $time, a, b); end end
module hxrl_loader_tb;
   logic ref_clk, reset_n, mem_wr_q, rec_err_q, load_done_q, start_valid_q;
   wire logic rx_valid;
   wire logic [7:0] rx_char;
   logic [19:0] mem_addr_q, start_addr_q;
   logic [7:0] mem_data_q, n;
   logic [28:0] q [$];
   logic [28:0] e, got;
   logic [15:0] a, seg;
   integer seed, n_mismatch, n_tests, cyc, k, j;
   // Free-running clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   hxrl_loader DUT (.ref_clk(ref_clk), .reset_n(reset_n),
      .rx_valid(rx_valid), .rx_char(rx_char), .mem_wr_q(mem_wr_q),
      .mem_addr_q(mem_addr_q), .mem_data_q(mem_data_q),
      .rec_err_q(rec_err_q), .load_done_q(load_done_q),
      .start_valid_q(start_valid_q), .start_addr_q(start_addr_q));
   hxrl_host host (.ref_clk(ref_clk), .rx_valid(rx_valid),
      .rx_char(rx_char));
   // Prints the counts and the verdict, then ends the run.
   task stop_test;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Random data record; each write is noted before sending.
   task data_rec(input [19:0] base);
      a = 16'($random(seed)) & 16'h7FFF;
      n = 8'h01 + (8'($random(seed)) & 8'h0F);
      for (j = 0; j < n; j = j + 1)
      begin
         host.dat[j] = 8'($random(seed));
         q.push_back({1'b0, base + {4'h0, a} + 20'(j), host.dat[j]});
      end
      host.send_rec(8'h00, a, n, 2'd0);
   endtask
   // Timeout, and comparison of each write or error with the oldest note.
   always @(negedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         stop_test;
      end
      else if (reset_n === 1'b1 && (mem_wr_q | rec_err_q) === 1'b1)
      begin
         `CHK(q.size() > 0, 1'b1)
         if (q.size() > 0)
         begin
            e = q.pop_front();
            got = rec_err_q ? 29'h1000_0000 : {1'b0, mem_addr_q, mem_data_q};
            `CHK(got, e)
         end
      end
   end
   // Main sequence of files and records.
   initial
   begin
      seed = 83;
      n_mismatch = 0;
      n_tests = 0;
      cyc = 0;
      reset_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      reset_n = 1'b1;
      data_rec(20'h0);
      for (k = 0; k < 3; k = k + 1)
      begin
         seg = 16'($random(seed));
         host.dat[0] = seg[15:8];
         host.dat[1] = seg[7:0];
         host.send_rec(8'h02, 16'h0, 8'h02, 2'd0);
         data_rec({seg, 4'h0});
         q.push_back(29'h1000_0000);
         host.send_rec(8'h00, 16'h10, 8'h01, 2'(k & 1) + 2'd1);
      end
      // Start segment is seg, start offset is seg with its bytes swapped.
      host.dat[0] = seg[15:8];
      host.dat[1] = seg[7:0];
      host.dat[2] = seg[7:0];
      host.dat[3] = seg[15:8];
      host.send_rec(8'h03, 16'h0, 8'h04, 2'd0);
      `CHK(start_valid_q, 1'b1)
      `CHK(start_addr_q, {seg, 4'h0} + {4'h0, seg[7:0], seg[15:8]})
      host.send_rec(8'h01, 16'h0, 8'h00, 2'd0);
      `CHK(load_done_q, 1'b1)
      // The new file is sent in lower-case digits, which the loader accepts.
      host.lc = 1'b1;
      data_rec(20'h0);
      `CHK(load_done_q, 1'b0)
      `CHK(q.size(), 0)
      stop_test;
   end
endmodule // hxrl_loader_tb
`default_nettype wire
